// >>> hdl/uief_top.sv
// Interrupt enable, identification and FIFO control of a 16550-style UART.
// Assumes the shifter supplies FIFO fill counts and interrupt source levels
// synchronous to core_clk_in, and consumes the FIFO clear pulses.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "uief_cfg.svh"

module uief_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W      = $clog2(FIFO_DEPTH) + 1
) (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    input  wire uief_pkg::uief_apb_req_t apb_req_in,
    output      uief_pkg::uief_apb_rsp_t apb_rsp_out,
    input  wire uief_pkg::uief_src_t     irq_src_in,
    input  wire logic [CNT_W-1:0]       rx_fifo_count_in,
    input  wire logic [CNT_W-1:0]       tx_fifo_count_in,
    output      uief_pkg::uief_pins_t    pins_out,
    output      logic [7:0]             baud_divisor_high_out
);
    import uief_pkg::*;

    // =================================================================
    // Level helpers

    // Receive trigger: 1 char, quarter, half, two below full.
    function automatic logic [CNT_W-1:0] rx_trigger_count(
        input logic [1:0] sel
    );
        logic [CNT_W-1:0] depth;
        depth = CNT_W'(FIFO_DEPTH);
        case (sel)
            2'h0: rx_trigger_count = CNT_W'(1);
            2'h1: rx_trigger_count = depth >> 2;
            2'h2: rx_trigger_count = depth >> 1;
            default: rx_trigger_count = depth - CNT_W'(2);
        endcase
    endfunction

    // Transmit threshold: empty, 2 chars, quarter, half.
    function automatic logic [CNT_W-1:0] tx_threshold_count(
        input logic [1:0] sel
    );
        logic [CNT_W-1:0] depth;
        depth = CNT_W'(FIFO_DEPTH);
        case (sel)
            2'h0: tx_threshold_count = CNT_W'(0);
            2'h1: tx_threshold_count = CNT_W'(2);
            2'h2: tx_threshold_count = depth >> 2;
            default: tx_threshold_count = depth >> 1;
        endcase
    endfunction

    // =================================================================
    // State

    uief_state_t st;
    uief_state_t next_st;

    logic        access;
    logic        commit;
    logic        hit_ier;
    logic        hit_iir;
    logic        hit_lcr;
    logic        hit_mcr;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [7:0]  ier_read;
    logic [7:0]  iir_read;
    logic [31:0] read_word;
    logic        fifo_on;
    logic        rx_at_trigger;
    logic        tx_at_threshold;
    logic        rx_avail;
    logic        tx_holding_empty_pend;
    logic        tmo_pend;
    logic [3:0]  code;

    assign apb_rsp_out           = st.rsp;
    assign pins_out              = st.pins;
    assign baud_divisor_high_out = st.baud_divisor_high;

    // =================================================================
    // Bus decode

    assign access  = apb_req_in.psel && apb_req_in.penable;
    // Writes land only at the edge where the master sees pready high.
    assign commit  = access && st.rsp.pready && apb_req_in.pwrite;
    assign hit_ier = apb_req_in.paddr == `UIEF_ADDR_IRQ_EN_DIV_HI;
    assign hit_iir = apb_req_in.paddr == `UIEF_ADDR_IDENT_FIFO_CTRL;
    assign hit_lcr = apb_req_in.paddr == `UIEF_ADDR_LINE_CTRL;
    assign hit_mcr = apb_req_in.paddr == `UIEF_ADDR_MODEM_CTRL;
    assign mapped  = hit_ier || hit_iir || hit_lcr || hit_mcr;
    assign wbyte   = apb_req_in.pwdata[7:0];

    // =================================================================
    // Interrupt sources and priority

    assign fifo_on         = st.pins.fifo_enable_bit;
    assign rx_at_trigger   = rx_fifo_count_in >=
                             rx_trigger_count(st.rx_trigger_level); // RL10
    assign tx_at_threshold = tx_fifo_count_in <=
                             tx_threshold_count(st.tx_empty_threshold); // RL13

    // Without FIFOs a single held character is the data-available event.
    assign rx_avail = fifo_on ? rx_at_trigger
                              : irq_src_in.rx_data_ready; // RL10

    // Programmable mode only has meaning with the FIFOs on.
    assign tx_holding_empty_pend = (st.prog_tx_empty_irq_mode && fifo_on) // RL1
                       ? tx_at_threshold // RL13
                       : irq_src_in.tx_holding_empty;

    assign tmo_pend = irq_src_in.char_timeout && fifo_on; // RL5

    always_comb begin
        if (irq_src_in.line_status && st.line_status_irq_en) begin // RL3
            code = `UIEF_ID_LINE;
        end else if (rx_avail && st.rx_data_irq_en) begin // RL5
            code = `UIEF_ID_RXDATA;
        end else if (tmo_pend && st.rx_data_irq_en) begin // RL5
            code = `UIEF_ID_TIMEOUT;
        end else if (tx_holding_empty_pend && st.tx_holding_empty_irq_en) begin // RL4
            code = `UIEF_ID_TX_HOLDING_EMPTY;
        end else if (irq_src_in.modem_status
                     && st.modem_status_irq_en) begin // RL2
            code = `UIEF_ID_MODEM;
        end else if (irq_src_in.busy_detect) begin
            // Busy detect has no enable and ranks below every other source.
            code = `UIEF_ID_BUSY;
        end else begin
            code = `UIEF_ID_NONE;
        end
    end

    // =================================================================
    // Read data

    always_comb begin
        if (st.pins.divisor_access_bit) begin
            ier_read = st.baud_divisor_high; // RL6
        end else begin
            // Bits 6:4 are reserved and read zero.
            ier_read = {st.prog_tx_empty_irq_mode, 3'h0,
                        st.modem_status_irq_en,
                        st.line_status_irq_en,
                        st.tx_holding_empty_irq_en,
                        st.rx_data_irq_en}; // RL20
        end
    end

    // The identification view is live state, never the stored control byte.
    assign iir_read = {{2{fifo_on}}, 2'h0, st.pending_irq_code}; // RL7 RL8

    always_comb begin
        read_word = `UIEF_RST_WORD;
        if (hit_ier) begin
            read_word[7:0] = ier_read;
        end else if (hit_iir) begin
            read_word[7:0] = iir_read; // RL7
        end else if (hit_lcr) begin
            read_word[`UIEF_LCR_DIV_ACC] = st.pins.divisor_access_bit;
        end else if (hit_mcr) begin
            read_word[`UIEF_MCR_AUTO_FLOW] = st.auto_flow_en;
            read_word[`UIEF_MCR_RTS_REQ]   = st.rts_request;
        end
    end

    // =================================================================
    // Next state

    always_comb begin
        next_st = st;

        // APB answer: one wait state, then pready for exactly one cycle.
        next_st.rsp.pready  = access && !st.rsp.pready;
        next_st.rsp.pslverr = access && !st.rsp.pready && !mapped;
        if (access && !st.rsp.pready && !apb_req_in.pwrite) begin
            next_st.rsp.prdata = read_word;
        end else begin
            next_st.rsp.prdata = `UIEF_RST_WORD;
        end

        // Clear strobes fall after one cycle without software help.
        next_st.pins.tx_fifo_clear = 1'b0; // RL15
        next_st.pins.rx_fifo_clear = 1'b0; // RL16

        if (commit && hit_ier) begin
            if (st.pins.divisor_access_bit) begin
                next_st.baud_divisor_high = wbyte; // RL6
            end else begin
                next_st.prog_tx_empty_irq_mode =
                    wbyte[`UIEF_IER_PROG_TX_HOLDING_EMPTY]; // RL1
                next_st.modem_status_irq_en =
                    wbyte[`UIEF_IER_MODEM]; // RL2
                next_st.line_status_irq_en =
                    wbyte[`UIEF_IER_LINE]; // RL3
                next_st.tx_holding_empty_irq_en =
                    wbyte[`UIEF_IER_TX_HOLDING_EMPTY]; // RL4
                next_st.rx_data_irq_en =
                    wbyte[`UIEF_IER_RXDATA]; // RL5
            end
        end

        if (commit && hit_iir) begin
            next_st.rx_trigger_level =
                wbyte[`UIEF_FCR_RXTRIG_HI:`UIEF_FCR_RXTRIG_LO]; // RL10
            next_st.tx_empty_threshold =
                wbyte[`UIEF_FCR_TXTHR_HI:`UIEF_FCR_TXTHR_LO]; // RL13
            next_st.dma_signal_mode =
                wbyte[`UIEF_FCR_DMA_MODE]; // RL14
            next_st.pins.tx_fifo_clear =
                wbyte[`UIEF_FCR_TX_CLEAR]; // RL15
            next_st.pins.rx_fifo_clear =
                wbyte[`UIEF_FCR_RX_CLEAR]; // RL16
            next_st.pins.fifo_enable_bit =
                wbyte[`UIEF_FCR_ENABLE]; // RL17
        end

        if (commit && hit_lcr) begin
            next_st.pins.divisor_access_bit =
                wbyte[`UIEF_LCR_DIV_ACC]; // RL18
        end

        if (commit && hit_mcr) begin
            next_st.auto_flow_en = wbyte[`UIEF_MCR_AUTO_FLOW];
            next_st.rts_request  = wbyte[`UIEF_MCR_RTS_REQ];
        end

        // Identification and interrupt line move together.
        next_st.pending_irq_code = code; // RL9
        next_st.pins.irq = code != `UIEF_ID_NONE; // RL19

        // Flow control only runs with the FIFOs on; otherwise the
        // request bit drives the line directly.
        if (st.auto_flow_en && fifo_on) begin
            next_st.pins.rts_n = !st.rts_request
                                 || rx_at_trigger; // RL11
        end else begin
            next_st.pins.rts_n = !st.rts_request;
        end

        // Mode 0 requests per character; mode 1 waits for the levels.
        if (st.dma_signal_mode && fifo_on) begin // RL14
            next_st.pins.dma_rx_req_n =
                !(rx_at_trigger || irq_src_in.char_timeout); // RL12
            next_st.pins.dma_tx_req_n = !tx_at_threshold; // RL13
        end else begin
            next_st.pins.dma_rx_req_n = fifo_on
                ? !(rx_fifo_count_in != CNT_W'(0))
                : !irq_src_in.rx_data_ready;
            next_st.pins.dma_tx_req_n = fifo_on
                ? !(tx_fifo_count_in == CNT_W'(0))
                : !irq_src_in.tx_holding_empty;
        end
    end

    // =================================================================
    // Register

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st                      <= '0; // RL20
            st.pending_irq_code     <= `UIEF_ID_NONE;
            st.pins.rts_n           <= 1'b1;
            st.pins.dma_rx_req_n    <= 1'b1;
            st.pins.dma_tx_req_n    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

endmodule // uief_top

// >>> hdl/uief_cfg.svh
// Constants of the UART interrupt-enable and FIFO-control register block.
// Assumes an APB master on a 100 MHz clock and 32-bit byte-addressed words.
//
// =====================================================================
// Notes on behaviour
// [RL1] Enable bit 7 turns the programmable transmit-empty interrupt mode on.
// [RL2] Enable bit 3 gates the modem status interrupt, fourth priority.
// [RL3] Enable bit 2 gates the line status interrupt, highest priority.
// [RL4] Enable bit 1 gates the transmit holding empty interrupt, third.
// [RL5] Enable bit 0 gates received data and character timeout, second.
// [RL6] With divisor access set, the enable address holds divisor high byte.
// [RL7] Shared address reads identification and writes separate FIFO control.
// [RL8] Identification bits 7:6 read 00 with FIFOs off, 11 with FIFOs on.
// [RL9] Identification bits 3:0 give the code of the top pending interrupt.
// [RL10] FIFO control bits 7:6 pick the receive trigger level.
// [RL11] Under automatic flow control, request-to-send drops at rx trigger.
// [RL12] The receive trigger level also steers the receive DMA request.
// [RL13] FIFO control bits 5:4 pick the transmit empty threshold.
// [RL14] FIFO control bit 3 picks DMA signalling mode 0 or 1.
// [RL15] Writing 1 to bit 2 empties the transmit FIFO and self-clears.
// [RL16] Writing 1 to bit 1 empties the receive FIFO and self-clears.
// [RL17] FIFO control bit 0 enables FIFOs; receive buffer reads FIFO head.
// [RL18] Software sets divisor access for baud setup and clears it after.
// [RL19] Interrupt output is high while any enabled source is pending.
// [RL20] Reserved bits read zero; all enables and settings reset to zero.
`ifndef UIEF_CFG_SVH
`define UIEF_CFG_SVH

// =====================================================================
// Register byte addresses
`define UIEF_ADDR_IRQ_EN_DIV_HI   32'h5000_1004
`define UIEF_ADDR_IDENT_FIFO_CTRL 32'h5000_1008
`define UIEF_ADDR_LINE_CTRL       32'h5000_100c
`define UIEF_ADDR_MODEM_CTRL      32'h5000_1010

// =====================================================================
// Field positions
`define UIEF_IER_PROG_TX_HOLDING_EMPTY 7
`define UIEF_IER_MODEM     3
`define UIEF_IER_LINE      2
`define UIEF_IER_TX_HOLDING_EMPTY      1
`define UIEF_IER_RXDATA    0
`define UIEF_FCR_RXTRIG_HI 7
`define UIEF_FCR_RXTRIG_LO 6
`define UIEF_FCR_TXTHR_HI  5
`define UIEF_FCR_TXTHR_LO  4
`define UIEF_FCR_DMA_MODE  3
`define UIEF_FCR_TX_CLEAR  2
`define UIEF_FCR_RX_CLEAR  1
`define UIEF_FCR_ENABLE    0
`define UIEF_LCR_DIV_ACC   7
`define UIEF_MCR_AUTO_FLOW 5
`define UIEF_MCR_RTS_REQ   1

// =====================================================================
// Interrupt identification codes
`define UIEF_ID_MODEM   4'h0
`define UIEF_ID_NONE    4'h1
`define UIEF_ID_TX_HOLDING_EMPTY    4'h2
`define UIEF_ID_RXDATA  4'h4
`define UIEF_ID_LINE    4'h6
`define UIEF_ID_BUSY    4'h7
`define UIEF_ID_TIMEOUT 4'hc

// =====================================================================
// Reset values
`define UIEF_RST_BYTE 8'h00
`define UIEF_RST_WORD 32'h0000_0000

`endif

// >>> hdl/uief_pkg.sv
// Types of the UART interrupt-enable and FIFO-control register block.
// Assumes the constants header is available to every user.
package uief_pkg;

    // =================================================================
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } uief_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } uief_apb_rsp_t;

    // =================================================================
    // Interrupt sources raised by the rest of the UART
    typedef struct packed {
        logic line_status;
        logic rx_data_ready;
        logic char_timeout;
        logic tx_holding_empty;
        logic modem_status;
        logic busy_detect;
    } uief_src_t;

    // =================================================================
    // Pins that leave the block
    typedef struct packed {
        logic irq;
        logic rts_n;
        logic dma_rx_req_n;
        logic dma_tx_req_n;
        logic tx_fifo_clear;
        logic rx_fifo_clear;
        logic fifo_enable_bit;
        logic divisor_access_bit;
    } uief_pins_t;

    // =================================================================
    // All state of the block
    typedef struct packed {
        logic [7:0]    baud_divisor_high;
        logic          prog_tx_empty_irq_mode;
        logic          modem_status_irq_en;
        logic          line_status_irq_en;
        logic          tx_holding_empty_irq_en;
        logic          rx_data_irq_en;
        logic [1:0]    rx_trigger_level;
        logic [1:0]    tx_empty_threshold;
        logic          dma_signal_mode;
        logic          auto_flow_en;
        logic          rts_request;
        logic [3:0]    pending_irq_code;
        uief_apb_rsp_t rsp;
        uief_pins_t    pins;
    } uief_state_t;

endpackage

// >>> testbench/uief_top_props.sv
// Concurrent checks on the ports of the interrupt-enable and FIFO block.
// Assumes one clock domain and the register map of the constants header.
`timescale 1ns/100ps
`include "uief_cfg.svh"

module uief_top_props #(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W      = $clog2(FIFO_DEPTH) + 1
) (
    input wire logic                    core_clk_in,
    input wire logic                    rst_n_in,
    input wire uief_pkg::uief_apb_req_t apb_req_in,
    input wire uief_pkg::uief_apb_rsp_t apb_rsp_out,
    input wire uief_pkg::uief_src_t     irq_src_in,
    input wire logic [CNT_W-1:0]        rx_fifo_count_in,
    input wire logic [CNT_W-1:0]        tx_fifo_count_in,
    input wire uief_pkg::uief_pins_t    pins_out,
    input wire logic [7:0]              baud_divisor_high_out
);
    import uief_pkg::*;
    // =================================================================
    // Helpers
    logic       done;
    logic       wr;
    logic       at_ctl;
    logic       mapped;
    logic       rxclr_req;
    logic [7:0] wbyte;
    assign done = apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready;
    assign wr = done && apb_req_in.pwrite;
    assign at_ctl = apb_req_in.paddr == `UIEF_ADDR_IDENT_FIFO_CTRL;
    assign mapped = apb_req_in.paddr inside {`UIEF_ADDR_IRQ_EN_DIV_HI,
        `UIEF_ADDR_IDENT_FIFO_CTRL, `UIEF_ADDR_LINE_CTRL,
        `UIEF_ADDR_MODEM_CTRL};
    assign rxclr_req = wr && at_ctl && apb_req_in.pwdata[1];
    assign wbyte = apb_req_in.pwdata[7:0];

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // =================================================================
    // Assertions
    a_answer_one_wait: assert property (
        apb_req_in.psel && !apb_req_in.penable |=>
        !apb_rsp_out.pready ##1 apb_rsp_out.pready)
        else $error("pready not in second access cycle");
    a_ready_one_cycle: assert property (
        apb_rsp_out.pready |=> !apb_rsp_out.pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (
        done && !mapped |-> apb_rsp_out.pslverr && apb_rsp_out.prdata == 0)
        else $error("unmapped access not refused");
    a_ident_upper: assert property (
        done && !apb_req_in.pwrite && at_ctl |-> apb_rsp_out.prdata[31:4] ==
        {24'h0, {2{pins_out.fifo_enable_bit}}, 2'b00})
        else $error("identification upper bits wrong");
    a_tx_clear_pulse: assert property (
        wr && at_ctl && apb_req_in.pwdata[2] |=>
        pins_out.tx_fifo_clear ##1 !pins_out.tx_fifo_clear)
        else $error("tx clear not a single pulse");
    a_rx_clear_cause: assert property (
        $rose(pins_out.rx_fifo_clear) |-> $past(rxclr_req))
        else $error("rx clear without a write");
    a_fifo_enable_set: assert property (
        wr && at_ctl && apb_req_in.pwdata[0] |=> pins_out.fifo_enable_bit)
        else $error("fifo enable not set");
    a_divisor_write: assert property (
        wr && apb_req_in.paddr == `UIEF_ADDR_IRQ_EN_DIV_HI &&
        pins_out.divisor_access_bit |=> baud_divisor_high_out == $past(wbyte))
        else $error("divisor high byte not written");
    a_busy_irq: assert property (
        irq_src_in.busy_detect |=> pins_out.irq)
        else $error("busy detect did not raise irq");
    a_idle_no_irq: assert property (
        irq_src_in == '0 && rx_fifo_count_in == 0 &&
        tx_fifo_count_in > CNT_W'(8) |=> !pins_out.irq)
        else $error("irq without a source");
endmodule // uief_top_props

bind uief_top uief_top_props #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
) i_props (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .apb_req_in(apb_req_in),
    .apb_rsp_out(apb_rsp_out),
    .irq_src_in(irq_src_in),
    .rx_fifo_count_in(rx_fifo_count_in),
    .tx_fifo_count_in(tx_fifo_count_in),
    .pins_out(pins_out),
    .baud_divisor_high_out(baud_divisor_high_out)
);

// >>> testbench/uief_far_end.sv
// Behavioural model of the UART core's FIFOs behind the block.
// Assumes the bench sets fill levels through the fill task.
`timescale 1ns/100ps

module uief_far_end #(
    parameter int CNT_W = 5
) (
    input  wire logic                 core_clk_in,
    input  wire uief_pkg::uief_pins_t pins_in,
    output      logic [CNT_W-1:0]     rx_fifo_count_out,
    output      logic [CNT_W-1:0]     tx_fifo_count_out
);
    import uief_pkg::*;
    initial begin
        rx_fifo_count_out = '0;
        tx_fifo_count_out = '0;
    end
    task automatic fill(input logic [CNT_W-1:0] rx,
                        input logic [CNT_W-1:0] tx);
        rx_fifo_count_out <= rx;
        tx_fifo_count_out <= tx;
    endtask
    // Clears win over nothing else: the bench never fills on a pulse edge.
    always @(posedge core_clk_in) begin
        if (pins_in.rx_fifo_clear) rx_fifo_count_out <= '0;
        if (pins_in.tx_fifo_clear) tx_fifo_count_out <= '0;
    end
endmodule // uief_far_end

// >>> testbench/tb_uart_irq_enable_fifo_control.sv
// Self-checking bench of the interrupt-enable and FIFO-control block.
// Assumes the design package, header, checker and far-end model.
`timescale 1ns/100ps
`include "uief_cfg.svh"

module tb_uart_irq_enable_fifo_control;
    import uief_pkg::*;
    typedef struct packed {
        logic [7:0] ier;
        uief_src_t  src;
        logic [3:0] code;
    } uief_row_t;
    localparam int          CW    = 5;
    localparam logic [31:0] A_IER = `UIEF_ADDR_IRQ_EN_DIV_HI;
    localparam logic [31:0] A_IIR = `UIEF_ADDR_IDENT_FIFO_CTRL;
    localparam logic [31:0] A_LCR = `UIEF_ADDR_LINE_CTRL;
    localparam logic [31:0] A_MCR = `UIEF_ADDR_MODEM_CTRL;
    logic          core_clk_in = 1'b0;
    logic          rst_n_in    = 1'b0;
    uief_apb_req_t req         = '0;
    uief_apb_rsp_t rsp;
    uief_src_t     src         = '0;
    uief_pins_t    pins;
    logic [CW-1:0] rxc;
    logic [CW-1:0] txc;
    logic [7:0]    div_hi;
    logic [31:0]   rd;
    logic          err;
    int            miscompares = 0;
    int            checks      = 0;
    uief_row_t     rows [10] = '{'{8'h04, 6'h30, 4'h6}, '{8'h01, 6'h30, 4'h4},
        '{8'h02, 6'h04, 4'h2}, '{8'h08, 6'h02, 4'h0}, '{8'h00, 6'h01, 4'h7},
        '{8'h0a, 6'h06, 4'h2}, '{8'h00, 6'h3e, 4'h1}, '{8'h01, 6'h08, 4'h1},
        '{8'h8f, 6'h3f, 4'h6}, '{8'h0f, 6'h1e, 4'h4}};
    logic [CW-1:0] trig [4] = '{5'd1, 5'd4, 5'd8, 5'd14};
    logic [CW-1:0] thr [4]  = '{5'd0, 5'd2, 5'd4, 5'd8};

    uief_top #(.FIFO_DEPTH(16), .CNT_W(CW)) i_dut (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .apb_req_in(req),
        .apb_rsp_out(rsp),
        .irq_src_in(src),
        .rx_fifo_count_in(rxc),
        .tx_fifo_count_in(txc),
        .pins_out(pins),
        .baud_divisor_high_out(div_hi)
    );
    uief_far_end #(.CNT_W(CW)) i_far (
        .core_clk_in(core_clk_in),
        .pins_in(pins),
        .rx_fifo_count_out(rxc),
        .tx_fifo_count_out(txc)
    );

    always #5 core_clk_in = ~core_clk_in;

    // =================================================================
    // Tasks
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask
    // The request stands until pready is seen; only the watchdog ends it.
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [7:0] d);
        @(posedge core_clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: {24'h0, d}};
        @(posedge core_clk_in);
        req.penable <= 1'b1;
        do @(posedge core_clk_in); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp, "read data");
    endtask
    task automatic settle(input logic [CW-1:0] r, input logic [CW-1:0] t);
        i_far.fill(r, t);
        repeat (3) @(posedge core_clk_in);
    endtask

    initial begin
        #100000;
        miscompares++;
        close_out();
    end

    // =================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        chk(pins, 32'h70, "reset pins");
        rdc(A_IER, 32'h0);
        rdc(A_IIR, 32'h1);
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, A_IER, rows[i].ier);
            src <= rows[i].src;
            repeat (2) @(posedge core_clk_in);
            rdc(A_IIR, {28'h0, rows[i].code});
            chk(pins.irq, rows[i].code != 4'h1, "irq level");
        end
        src <= '0;
        apb(1'b1, A_IER, 8'hff);
        rdc(A_IER, 32'h8f);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_IER, 8'h81);
            apb(1'b1, A_IIR, {i[1:0], i[1:0], 4'b1001});
            settle(trig[i] - 5'd1, thr[i] + 5'd1);
            rdc(A_IIR, 32'hc1);
            chk({pins.dma_rx_req_n, pins.dma_tx_req_n}, 2'b11, "dma");
            settle(trig[i], thr[i]);
            rdc(A_IIR, 32'hc4);
            chk({pins.dma_rx_req_n, pins.dma_tx_req_n}, 2'b00, "dma");
            apb(1'b1, A_IER, 8'h82);
            rdc(A_IIR, 32'hc2);
        end
        apb(1'b1, A_IER, 8'h02);
        rdc(A_IIR, 32'hc1);
        apb(1'b1, A_IIR, 8'hf1);
        settle(5'd2, 5'd2);
        chk({pins.dma_rx_req_n, pins.dma_tx_req_n}, 2'b01, "mode 0");
        apb(1'b1, A_IIR, 8'hf9);
        apb(1'b1, A_MCR, 8'h22);
        rdc(A_MCR, 32'h22);
        settle(5'd13, 5'd2);
        chk({pins.dma_rx_req_n, pins.dma_tx_req_n}, 2'b10, "mode 1");
        chk(pins.rts_n, 1'b0, "rts below");
        settle(5'd14, 5'd2);
        chk(pins.rts_n, 1'b1, "rts at trigger");
        apb(1'b1, A_IIR, 8'h07);
        repeat (2) @(posedge core_clk_in);
        chk({rxc, txc}, 32'h0, "fifo clear");
        settle(5'd0, 5'd9);
        apb(1'b1, A_IER, 8'h01);
        src <= 6'h08;
        repeat (2) @(posedge core_clk_in);
        rdc(A_IIR, 32'hcc);
        apb(1'b1, A_LCR, 8'h80);
        rdc(A_LCR, 32'h80);
        chk(pins.divisor_access_bit, 1'b1, "divisor access pin");
        apb(1'b1, A_IER, 8'ha5);
        rdc(A_IER, 32'ha5);
        chk(div_hi, 8'ha5, "divisor high");
        apb(1'b1, A_LCR, 8'h00);
        rdc(A_IER, 32'h01);
        apb(1'b0, 32'h5000_1020, 8'h00);
        chk(rd, 32'h0, "unmapped data");
        chk({31'h0, err}, 32'h1, "unmapped error");
        rst_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        chk(pins, 32'h70, "reset again");
        rst_n_in <= 1'b1;
        rdc(A_IER, 32'h0);
        close_out();
    end
endmodule // tb_uart_irq_enable_fifo_control
